// ---- pkg/frt_defs.svh ----
/*
 Register offsets, field positions, reset values and divider masks of the
 free-running timer. Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FRT_OFS_STAT 8'h00
`define FRT_OFS_CTRL 8'h04
`define FRT_OFS_CNT 8'h08
`define FRT_OFS_CMPA 8'h0C
`define FRT_OFS_CMPB 8'h10
`define FRT_OFS_CAPA 8'h14
`define FRT_OFS_CAPB 8'h18
`define FRT_OFS_CAPC 8'h1C
`define FRT_OFS_CAPD 8'h20
`define FRT_OFS_IRQ_STAT 8'h24
`define FRT_OFS_IRQ_CLR 8'h28
`define FRT_OFS_IRQ_EN 8'h2C
// ------------------------------------------------------------
// status register bits
// ------------------------------------------------------------
`define FRT_BIT_CAPA 7
`define FRT_BIT_CAPD 4
`define FRT_BIT_CMPA 3
`define FRT_BIT_CMPB 2
`define FRT_BIT_WRAP 1
`define FRT_BIT_CLRA 0
// ------------------------------------------------------------
// reset values and counter constants
// ------------------------------------------------------------
`define FRT_CTRL_RST 8'h00
`define FRT_STAT_RST 7'h00
`define FRT_CNT_RST 16'h0000
`define FRT_CNT_ALL1 16'hFFFF
`define FRT_CMP_RST 16'hFFFF
`define FRT_DIV2_MASK 5'h01
`define FRT_DIV8_MASK 5'h07
`define FRT_DIV32_MASK 5'h1F
`endif

// ---- pkg/frt_pkg.sv ----
/*
 Types shared by the free-running timer: the clock-select code and the
 layout of the timer control register. Assumes nothing of its surroundings.
*/
package frt_pkg;
   // clock source codes, in register encoding order
   typedef enum logic [1:0] {
      FRT_CK_DIV2,
      FRT_CK_DIV8,
      FRT_CK_DIV32,
      FRT_CK_EXT
   } frt_cks_t;

   // timer control register, bit 7 down to bit 0
   typedef struct packed {
      logic [3:0] edge_sel;
      logic buffer_mode_a;
      logic buffer_mode_b;
      frt_cks_t clk_sel;
   } frt_ctrl_t;
endpackage : frt_pkg

// ---- design/frt_timer.sv ----
/*
 Free-running 16-bit timer with two compare channels, overflow, four
 capture pins and capture buffering, reached over Avalon-MM.
 Assumes capture and external count pins are already synchronous to clk_i.
*/
`include "frt_defs.svh"

module frt_timer #(
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic capture_pin_a_i,
   input wire logic capture_pin_b_i,
   input wire logic capture_pin_c_i,
   input wire logic capture_pin_d_i,
   input wire logic ext_count_pin_i,
   output logic compare_a_evt_o,
   output logic compare_b_evt_o,
   output logic wrap_evt_o,
   output logic irq_o
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   // the register map and wrap constant are sized for a 16-bit counter
   if (CNT_W != 16) begin : g_bad_width
      $error("frt_timer supports only CNT_W = 16");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   frt_pkg::frt_ctrl_t ctrl_q;
   logic [CNT_W-1:0] cnt_q, cmp_a_q, cmp_b_q;
   logic [CNT_W-1:0] cap_q [4];
   logic [7:1] flag_q, flag_d, armed_q, armed_d, flag_set;
   logic clr_on_a_q;
   logic [4:0] presc_q;
   logic [3:0] pin_q;
   logic ext_q;
   logic [2:0] irq_stat_q, irq_en_q;
   logic ack_q;
   logic [31:0] rdata_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one wait cycle: read data are registered before the answer
   wire req = read_i | write_i;
   wire acc = req & ack_q;
   wire wr = write_i & acc;
   wire rd = read_i & acc;
   wire wr_stat = wr && address_i == `FRT_OFS_STAT;
   wire rd_stat = rd && address_i == `FRT_OFS_STAT;
   wire wr_ctrl = wr && address_i == `FRT_OFS_CTRL;
   wire wr_cnt = wr && address_i == `FRT_OFS_CNT;
   wire wr_cmpa = wr && address_i == `FRT_OFS_CMPA;
   wire wr_cmpb = wr && address_i == `FRT_OFS_CMPB;
   wire wr_iclr = wr && address_i == `FRT_OFS_IRQ_CLR;
   wire wr_ien = wr && address_i == `FRT_OFS_IRQ_EN;
   assign waitrequest_o = ~ack_q;
   assign readdata_o = rdata_q;

   // read multiplexer; unmapped offsets read as zero
   wire [7:0] stat_rd = {flag_q, clr_on_a_q};
   wire [31:0] rd_mux =
      address_i == `FRT_OFS_STAT ? {24'h000000, stat_rd} :
      address_i == `FRT_OFS_CTRL ? {24'h000000, ctrl_q} :
      address_i == `FRT_OFS_CNT ? {16'h0000, cnt_q} :
      address_i == `FRT_OFS_CMPA ? {16'h0000, cmp_a_q} :
      address_i == `FRT_OFS_CMPB ? {16'h0000, cmp_b_q} :
      address_i == `FRT_OFS_CAPA ? {16'h0000, cap_q[0]} :
      address_i == `FRT_OFS_CAPB ? {16'h0000, cap_q[1]} :
      address_i == `FRT_OFS_CAPC ? {16'h0000, cap_q[2]} :
      address_i == `FRT_OFS_CAPD ? {16'h0000, cap_q[3]} :
      address_i == `FRT_OFS_IRQ_STAT ? {29'h00000000, irq_stat_q} :
      address_i == `FRT_OFS_IRQ_EN ? {29'h00000000, irq_en_q} : 32'h00000000;

   // bus handshake and read data
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         if (read_i & ~ack_q) rdata_q <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // prescaler and count tick
   // ------------------------------------------------------------
   function automatic logic edge_hit(input logic prev, input logic now, input logic rise);
      edge_hit = rise ? (~prev & now) : (prev & ~now);
   endfunction : edge_hit

   wire [4:0] div_mask =
      ctrl_q.clk_sel == frt_pkg::FRT_CK_DIV2 ? `FRT_DIV2_MASK :
      ctrl_q.clk_sel == frt_pkg::FRT_CK_DIV8 ? `FRT_DIV8_MASK : `FRT_DIV32_MASK;
   wire ext_sel = ctrl_q.clk_sel == frt_pkg::FRT_CK_EXT;
   wire ext_rise = edge_hit(ext_q, ext_count_pin_i, 1'b1);
   wire tick = ext_sel ? ext_rise : (presc_q & div_mask) == div_mask;

   // free prescaler and external pin history
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         presc_q <= 5'h00;
         ext_q <= 1'b0;
      end else begin
         presc_q <= presc_q + 5'h01;
         ext_q <= ext_count_pin_i;
      end
   end

   // ------------------------------------------------------------
   // counter and compare
   // ------------------------------------------------------------
   wire match_a = cnt_q == cmp_a_q;
   wire match_b = cnt_q == cmp_b_q;
   wire clr_now = tick & match_a & clr_on_a_q;
   wire wrap_ev = tick & ~clr_now & ~wr_cnt & cnt_q == `FRT_CNT_ALL1;
   assign compare_a_evt_o = flag_q[`FRT_BIT_CMPA];
   assign compare_b_evt_o = flag_q[`FRT_BIT_CMPB];
   assign wrap_evt_o = flag_q[`FRT_BIT_WRAP];

   // a software write to the counter wins over the tick
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= `FRT_CNT_RST;
         cmp_a_q <= `FRT_CMP_RST;
         cmp_b_q <= `FRT_CMP_RST;
         ctrl_q <= `FRT_CTRL_RST;
         clr_on_a_q <= 1'b0;
      end else begin
         if (wr_cnt) cnt_q <= writedata_i[CNT_W-1:0];
         else if (clr_now) cnt_q <= `FRT_CNT_RST;
         else if (tick) cnt_q <= cnt_q + 16'h0001;
         if (wr_cmpa) cmp_a_q <= writedata_i[CNT_W-1:0];
         if (wr_cmpb) cmp_b_q <= writedata_i[CNT_W-1:0];
         if (wr_ctrl) ctrl_q <= writedata_i[7:0];
         if (wr_stat) clr_on_a_q <= writedata_i[`FRT_BIT_CLRA];
      end
   end

   // ------------------------------------------------------------
   // input capture
   // ------------------------------------------------------------
   wire [3:0] pins = {capture_pin_d_i, capture_pin_c_i, capture_pin_b_i, capture_pin_a_i};
   logic [3:0] cap_ev;
   for (genvar k = 0; k < 4; k++) begin : g_edge
      assign cap_ev[k] = edge_hit(pin_q[k], pins[k], ctrl_q.edge_sel[3-k]);
   end
   wire buf_a = ctrl_q.buffer_mode_a;
   wire buf_b = ctrl_q.buffer_mode_b;

   // in buffer mode the older capture moves into C or D and the pin
   // of C or D only raises its flag, so no value is lost to it
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_q <= 4'h0;
         for (int k = 0; k < 4; k++) cap_q[k] <= `FRT_CNT_RST;
      end else begin
         pin_q <= pins;
         if (cap_ev[0]) cap_q[0] <= cnt_q;
         if (cap_ev[1]) cap_q[1] <= cnt_q;
         if (buf_a) begin
            if (cap_ev[0]) cap_q[2] <= cap_q[0];
         end else if (cap_ev[2]) cap_q[2] <= cnt_q;
         if (buf_b) begin
            if (cap_ev[1]) cap_q[3] <= cap_q[1];
         end else if (cap_ev[3]) cap_q[3] <= cnt_q;
      end
   end

   // ------------------------------------------------------------
   // status flags: read as 1, then write 0
   // ------------------------------------------------------------
   assign flag_set = {cap_ev[0], cap_ev[1], cap_ev[2], cap_ev[3], match_a, match_b, wrap_ev};
   for (genvar i = 1; i < 8; i++) begin : g_flag
      // a flag is armed by a read that returned it as 1; set wins over clear
      wire clr = wr_stat & ~writedata_i[i] & armed_q[i];
      assign flag_d[i] = flag_set[i] | (flag_q[i] & ~clr);
      assign armed_d[i] = (rd_stat & rdata_q[i]) | (armed_q[i] & ~wr_stat);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_q <= `FRT_STAT_RST;
         armed_q <= `FRT_STAT_RST;
      end else begin
         flag_q <= flag_d;
         armed_q <= armed_d;
      end
   end

   // ------------------------------------------------------------
   // interrupt status, clear and enable
   // ------------------------------------------------------------
   wire [2:0] irq_ev = {match_a, match_b, wrap_ev};
   assign irq_o = |(irq_stat_q & irq_en_q);

   // the write-one clear loses to an event in the same cycle
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat_q <= 3'h0;
         irq_en_q <= 3'h0;
      end else begin
         irq_stat_q <= irq_ev | (irq_stat_q & ~({3{wr_iclr}} & writedata_i[2:0]));
         if (wr_ien) irq_en_q <= writedata_i[2:0];
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   cmp_a_set_a: assert property (match_a |=> flag_q[3])
      else $error("compare-A flag not set on match");
   cmp_b_set_a: assert property (match_b |=> flag_q[2])
      else $error("compare-B flag not set on match");
   cmp_a_hold_a: assert property (flag_q[3] && wr_stat && writedata_i[3] |=> flag_q[3])
      else $error("compare-A flag cleared by writing one");
   cmp_b_clear_a: assert property (
      flag_q[2] && !match_b && wr_stat && !writedata_i[2] && !armed_q[2] |=> flag_q[2])
      else $error("compare-B flag cleared without a prior read");
   wrap_flag_a: assert property (tick && !clr_now && !wr_cnt && cnt_q == 16'hFFFF
      |=> cnt_q == 16'h0000 && flag_q[1])
      else $error("wrap did not set the wrap flag");
   wrap_hold_a: assert property (flag_q[1] && wr_stat && writedata_i[1] |=> flag_q[1])
      else $error("wrap flag cleared by writing one");
   match_clear_a: assert property (tick && match_a && clr_on_a_q && !wr_cnt
      |=> cnt_q == 16'h0000)
      else $error("counter not cleared on compare-match A");
   count_up_a: assert property (tick && !clr_now && !wr_cnt
      |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
      else $error("counter did not advance by one");
   capture_a_a: assert property (cap_ev[0] |=> cap_q[0] == $past(cnt_q))
      else $error("capture A missed the counter value");
   buffer_c_a: assert property (buf_a && cap_ev[2] && !cap_ev[0] && !$past(wr_ctrl)
      |=> cap_q[2] == $past(cap_q[2]) && flag_q[5])
      else $error("capture C transferred in buffer mode");
   div8_rate_a: assert property (ctrl_q.clk_sel == frt_pkg::FRT_CK_DIV8 && tick && !wr_ctrl
      |=> !tick [*7])
      else $error("divide-by-8 tick came early");
   ext_tick_a: assert property (ext_sel && ext_rise |-> tick)
      else $error("external rising edge did not tick");
endmodule : frt_timer

// ---- dv/frt_tb.sv ----
/*
 Self-checking bench of the free-running timer: Avalon-MM accesses, capture
 pins and the external count pin. Assumes frt_defs.svh on the include path.
*/
`include "frt_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, nrst_i, read_i, write_i, waitrequest_o, ext_count_pin_i, irq_o;
   logic compare_a_evt_o, compare_b_evt_o, wrap_evt_o;
   logic [7:0] address_i;
   logic [31:0] writedata_i, readdata_o, q, rnd;
   logic [3:0] cap, es;
   logic [15:0] k, k2, k3;
   logic [15:0] exp_cap [4];
   int errors, samples_checked, cyc, lo;

   frt_timer i_frt_timer (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .capture_pin_a_i(cap[3]), .capture_pin_b_i(cap[2]), .capture_pin_c_i(cap[1]),
      .capture_pin_d_i(cap[0]), .ext_count_pin_i(ext_count_pin_i),
      .compare_a_evt_o(compare_a_evt_o), .compare_b_evt_o(compare_b_evt_o),
      .wrap_evt_o(wrap_evt_o), .irq_o(irq_o));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int div_of(input frt_pkg::frt_cks_t c);
      return (c == frt_pkg::FRT_CK_DIV2) ? 2 : (c == frt_pkg::FRT_CK_DIV8) ? 8 : 32;
   endfunction : div_of

   // one access; held until waitrequest low, then an idle edge so no re-raise races
   // no local limit: only the cycle guard below ends a wait that never answers
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      address_i <= a;
      writedata_i <= d;
      read_i <= ~wr;
      write_i <= wr;
      do begin
         @(posedge clk_i);
      end while (waitrequest_o !== 1'b0);
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   // selected edge on the masked pins, then back; the return edge must not capture
   task automatic fire(input logic [3:0] m);
      cap <= (es & m) | (~es & ~m);
      repeat (3) @(posedge clk_i);
      cap <= ~es;
      repeat (3) @(posedge clk_i);
   endtask : fire

   task automatic tick(input int n);
      repeat (n) begin
         ext_count_pin_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         ext_count_pin_i <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask : tick

   task automatic stop_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         stop_test();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {nrst_i, read_i, write_i, ext_count_pin_i, address_i, writedata_i, cap} = '0;
      rnd = 32'h3B855833;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      // reset values and an unmapped place
      bus(1'b0, `FRT_OFS_STAT, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, `FRT_OFS_CTRL, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, 8'h3C, 32'h0);
      `CHK(q, 32'h0)
      // prescaled rates; phase of the prescaler leaves one tick of slack
      for (int c = 0; c < 3; c++) begin
         lo = 65 / div_of(frt_pkg::frt_cks_t'(c));
         bus(1'b1, `FRT_OFS_CTRL, c);
         bus(1'b1, `FRT_OFS_CNT, 32'h0);
         repeat (64) @(posedge clk_i);
         bus(1'b0, `FRT_OFS_CNT, 32'h0);
         `CHK(q >= lo && q <= lo + 1, 1'b1)
      end
      // external pin; counter frozen between pulses, used by later cases
      rnd = lfsr(rnd);
      k = {1'b0, rnd[14:0]};
      bus(1'b1, `FRT_OFS_CTRL, 32'h3);
      bus(1'b1, `FRT_OFS_CNT, {16'h0, k});
      tick(5);
      bus(1'b0, `FRT_OFS_CNT, 32'h0);
      `CHK(q[15:0], k + 16'h5)
      // compare flags: set on match, ones ignored, zero needs a prior read
      for (int ch = 0; ch < 2; ch++) begin
         rnd = lfsr(rnd);
         k = {1'b0, rnd[14:0]};
         bus(1'b1, ch ? `FRT_OFS_CMPB : `FRT_OFS_CMPA, {16'h0, k});
         bus(1'b1, `FRT_OFS_CNT, {16'h0, k});
         bus(1'b0, `FRT_OFS_STAT, 32'h0);
         `CHK(q[3 - ch], 1'b1)
         bus(1'b1, ch ? `FRT_OFS_CMPB : `FRT_OFS_CMPA, {16'h0, k + 16'h1});
         bus(1'b1, `FRT_OFS_STAT, 32'hE);
         `CHK(ch ? compare_b_evt_o : compare_a_evt_o, 1'b1)
         bus(1'b1, `FRT_OFS_STAT, 32'h0);
         `CHK(ch ? compare_b_evt_o : compare_a_evt_o, 1'b1)
         bus(1'b0, `FRT_OFS_STAT, 32'h0);
         bus(1'b1, `FRT_OFS_STAT, 32'h0);
         `CHK(ch ? compare_b_evt_o : compare_a_evt_o, 1'b0)
      end
      // wrap from all ones
      bus(1'b1, `FRT_OFS_CNT, 32'hFFFF);
      tick(1);
      `CHK(wrap_evt_o, 1'b1)
      bus(1'b0, `FRT_OFS_CNT, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b0, `FRT_OFS_STAT, 32'h0);
      bus(1'b1, `FRT_OFS_STAT, 32'h0);
      `CHK(wrap_evt_o, 1'b0)
      // interrupt status, enable and clear
      bus(1'b1, `FRT_OFS_IRQ_STAT, 32'h0);
      bus(1'b0, `FRT_OFS_IRQ_STAT, 32'h0);
      `CHK(q, 32'h7)
      `CHK(irq_o, 1'b0)
      bus(1'b1, `FRT_OFS_IRQ_EN, 32'h1);
      `CHK(irq_o, 1'b1)
      bus(1'b1, `FRT_OFS_IRQ_EN, 32'h4);
      bus(1'b1, `FRT_OFS_IRQ_CLR, 32'h4);
      `CHK(irq_o, 1'b0)
      bus(1'b0, `FRT_OFS_IRQ_STAT, 32'h0);
      `CHK(q, 32'h3)
      // clear on compare-match A, on and off
      bus(1'b1, `FRT_OFS_CTRL, 32'h0);
      bus(1'b1, `FRT_OFS_CMPA, 32'h10);
      for (int on = 1; on >= 0; on--) begin
         bus(1'b1, `FRT_OFS_STAT, on);
         bus(1'b1, `FRT_OFS_CNT, 32'h0);
         repeat (80) @(posedge clk_i);
         bus(1'b0, `FRT_OFS_CNT, 32'h0);
         `CHK(q <= 32'h10, on == 1)
      end
      // captures on random edges, then buffering pairs A/C and B/D
      rnd = lfsr(rnd);
      es = rnd[3:0];
      {k, k2} = rnd ^ 32'h5A5A3C3C;
      k3 = k ^ 16'h0F0F;
      cap <= ~es;
      bus(1'b1, `FRT_OFS_CTRL, {24'h0, es, 4'h3});
      bus(1'b1, `FRT_OFS_CNT, {16'h0, k});
      fire(4'hF);
      bus(1'b0, `FRT_OFS_STAT, 32'h0);
      `CHK(q[7:4], 4'hF)
      bus(1'b1, `FRT_OFS_CNT, {16'h0, k2});
      fire(4'hC);
      bus(1'b1, `FRT_OFS_CTRL, {24'h0, es, 4'hF});
      bus(1'b1, `FRT_OFS_CNT, {16'h0, k3});
      fire(4'hF);
      exp_cap = '{k3, k3, k2, k2};
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, `FRT_OFS_CAPA + 8'(4 * i), 32'h0);
         `CHK(q[15:0], exp_cap[i])
      end
      // buffer mode A: a lone pin-C edge raises flag C and leaves capture C alone
      bus(1'b0, `FRT_OFS_STAT, 32'h0);
      bus(1'b1, `FRT_OFS_STAT, 32'h0);
      fire(4'h2);
      bus(1'b0, `FRT_OFS_STAT, 32'h0);
      `CHK(q[7:4], 4'h2)
      bus(1'b0, `FRT_OFS_CAPC, 32'h0);
      `CHK(q[15:0], k2)
      stop_test();
   end
endmodule : testbench
